// file: inc/srs_pkg.sv
// Package for the serial readback-select block
// Assumes a 24-bit serial frame, one system clock
package srs_pkg;
    // ==========================================
    // Frame layout
    localparam int FRAME_BITS   = 24;
    localparam int DATA_BITS    = 16;
    localparam int MODE_HI      = 23;
    localparam int MODE_LO      = 22;
    localparam int FUNC_HI      = 21;
    localparam int FUNC_LO      = 16;
    localparam int SEL_HI       = 15;
    localparam int SEL_LO       = 7;
    localparam int LOW7_HI      = 6;
    // ==========================================
    // Codes
    localparam logic [1:0] MODE_SPECIAL  = 2'h0;
    localparam logic [5:0] FUNC_READBACK = 6'h05;
    localparam logic [2:0] GRP_PRIMARY   = 3'h0;
    localparam logic [2:0] GRP_ALTERNATE = 3'h1;
    localparam logic [2:0] GRP_OFFSET    = 3'h2;
    localparam logic [2:0] GRP_GAIN      = 3'h3;
    localparam logic [8:0] SEL_CONTROL   = 9'h101;
    localparam logic [8:0] SEL_OFFSET_DAC_ZERO      = 9'h102;
    localparam logic [8:0] SEL_OFFSET_DAC_ONE      = 9'h103;
    localparam logic [8:0] SEL_AB0       = 9'h106;
    localparam logic [8:0] SEL_AB1       = 9'h107;
    localparam logic [8:0] SEL_GPIO      = 9'h10B;
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    typedef enum logic [3:0] {
        SRS_SRC_NONE, SRS_SRC_PRI, SRS_SRC_ALT, SRS_SRC_OFS, SRS_SRC_GAIN,
        SRS_SRC_CTRL, SRS_SRC_DAC0, SRS_SRC_DAC1, SRS_SRC_AB0, SRS_SRC_AB1,
        SRS_SRC_GPIO
    } srs_src_t;
endpackage

// file: inc/srs_sel_if.sv
// Interface carrying a decoded selection between decoder and top
// Assumes both ends share clk
`timescale 1ns/1ps
interface srs_sel_if;
    logic                    valid;
    srs_pkg::srs_src_t       src;
    logic [2:0]              chan;
    modport dec (output valid, output src, output chan);
    modport top (input valid, input src, input chan);
endinterface

// file: hw/srs_decode.sv
// Combinational decoder of a readback-select frame
// Assumes a full frame word, stable while frame_done is high
`timescale 1ns/1ps
module srs_decode (
    // Frame in
    input  wire logic [23:0] frame,
    input  wire logic        frame_done,
    // Decoded selection
    srs_sel_if.dec           sel
);
    import srs_pkg::*;
    logic [8:0] code;
    assign code = frame[SEL_HI:SEL_LO];
    // Readback request detection and code decode
    always_comb begin
        sel.valid = frame_done && frame[MODE_HI:MODE_LO] == MODE_SPECIAL
                    && frame[FUNC_HI:FUNC_LO] == FUNC_READBACK; // [RL1]
        sel.chan  = code[2:0];                                  // [RL2]
        sel.src   = SRS_SRC_NONE;
        case (code[8:6])
            GRP_PRIMARY:   sel.src = SRS_SRC_PRI;               // [RL2]
            GRP_ALTERNATE: sel.src = SRS_SRC_ALT;
            GRP_OFFSET:    sel.src = SRS_SRC_OFS;
            GRP_GAIN:      sel.src = SRS_SRC_GAIN;
            default: begin
                // System registers; low field bits not examined [RL4]
                case (code)
                    SEL_CONTROL: sel.src = SRS_SRC_CTRL;        // [RL3]
                    SEL_OFFSET_DAC_ZERO:    sel.src = SRS_SRC_DAC0;
                    SEL_OFFSET_DAC_ONE:    sel.src = SRS_SRC_DAC1;
                    SEL_AB0:     sel.src = SRS_SRC_AB0;
                    SEL_AB1:     sel.src = SRS_SRC_AB1;
                    SEL_GPIO:    sel.src = SRS_SRC_GPIO;        // [RL5]
                    default:     sel.src = SRS_SRC_NONE;
                endcase
            end
        endcase
    end
endmodule // srs_decode

// file: hw/srs_readback.sv
// Contract
// (RL1) Readback is a special-function frame, mode 00, readback function code.
// (RL2) Top select bits 000..011 pick primary, alternate, offset or gain register.
// (RL3) Select 1000000xx-style codes pick control, offset DACs, A/B selects.
// (RL4) Lowest seven field bits are ignored except for pin readback; the code ignores them for pin readback too.
// (RL5) Pin readback returns the sampled pin level in data bit 0.
// (RL6) Host drives lowest seven field bits to zero for pin readback.
// (RL7) Input-configured pin level is what bit 0 reports.
// (RL8) Host first sends a frame naming the register to read.
// (RL9) Next frame is a no-op; selected contents shift out during it.
//
// Top of the serial readback-select block
// Assumes sclk, sync_n, sdi and gpio_pin are raw pins, sampled into clk
// Assumes register contents arrive flat, channel c in bits [c*16 +: 16]
// Assumes sclk idles high and each sclk phase lasts at least five clk cycles
// Assumes at least six clk cycles of sync_n high between two frames
// Response frame: eight zero bits, then the 16-bit word, MSB first
// Frames of any length but 24 bits are dropped and cancel a pending response
`timescale 1ns/1ps
module srs_readback #(
    parameter int CHANNELS = 8
) (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Serial pins
    input  wire logic                    sclk,
    input  wire logic                    sync_n,
    input  wire logic                    sdi,
    output logic                         sdo,
    // Register contents to read back
    input  wire logic [CHANNELS*16-1:0]  primary_input_reg,
    input  wire logic [CHANNELS*16-1:0]  alternate_input_reg,
    input  wire logic [CHANNELS*16-1:0]  offset_trim_reg,
    input  wire logic [CHANNELS*16-1:0]  gain_trim_reg,
    input  wire logic [15:0]             control_reg,
    input  wire logic [15:0]             offset_dac_zero,
    input  wire logic [15:0]             offset_dac_one,
    input  wire logic [15:0]             ab_select_zero,
    input  wire logic [15:0]             ab_select_one,
    // General-purpose pin
    input  wire logic                    gpio_is_output,
    input  wire logic                    gpio_pin,
    // Frame out
    output logic                         frame_valid,
    output logic [srs_pkg::FRAME_BITS-1:0] frame_word
);
    import srs_pkg::*;

    // ==========================================
    // Pin synchronisers
    // Every pin passes two flip-flops before any logic reads it; only the
    // second stage is used downstream, the first may still be metastable.
    logic [1:0] sclk_s_q, sync_s_q, sdi_s_q, gpio_s_q;
    logic       sclk_d1_q, sync_d1_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            // Serial clock and frame select reset to their idle-high levels,
            // so release of reset is not mistaken for an edge on either pin
            sclk_s_q <= 2'h3;
            sync_s_q <= 2'h3;
            sdi_s_q  <= 2'h0;
            gpio_s_q <= 2'h0;
        end else begin
            sclk_s_q <= {sclk_s_q[0], sclk};
            sync_s_q <= {sync_s_q[0], sync_n};
            sdi_s_q  <= {sdi_s_q[0], sdi};
            gpio_s_q <= {gpio_s_q[0], gpio_pin};
        end
    end
    // Edge history of synchronised levels
    // Reset values match the idle pins, so no false edge follows reset
    always_ff @(posedge clk) begin
        if (rst) begin
            sclk_d1_q <= 1'b1;
            sync_d1_q <= 1'b1;
        end else begin
            sclk_d1_q <= sclk_s_q[1];
            sync_d1_q <= sync_s_q[1];
        end
    end
    // Edge strobes, one clk cycle wide each
    // frame_end marks the synced rise of sync_n; in_frame is its low level
    logic sclk_fall, sclk_rise, frame_end, in_frame;
    assign sclk_fall = sclk_d1_q && !sclk_s_q[1];
    assign sclk_rise = !sclk_d1_q && sclk_s_q[1];
    assign frame_end = !sync_d1_q && sync_s_q[1];
    assign in_frame  = !sync_s_q[1];

    // ==========================================
    // Input shifting on falling serial clock
    logic [FRAME_BITS-1:0] shift_q;
    logic [4:0]            cnt_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            shift_q <= '0;
            cnt_q   <= 5'h00;
        end else if (!in_frame) begin
            cnt_q <= 5'h00;
        end else if (sclk_fall) begin
            shift_q <= {shift_q[FRAME_BITS-2:0], sdi_s_q[1]};
            // Saturate so an overlong frame cannot wrap back to 24
            if (cnt_q != '1)
                cnt_q <= cnt_q + 5'h01;
        end
    end
    // Only an exact 24-bit frame counts; short or long ones are dropped
    logic full_frame;
    assign full_frame = frame_end && cnt_q == 5'(FRAME_BITS);

    // Captured frame handed out
    // frame_valid pulses once per good frame; frame_word holds until the next
    always_ff @(posedge clk) begin
        if (rst) begin
            frame_valid <= 1'b0;
            frame_word  <= '0;
        end else begin
            frame_valid <= full_frame;
            if (full_frame)
                frame_word <= shift_q;
        end
    end

    // ==========================================
    // Decode
    // The decoder looks straight at the shift register; its result is used
    // only in the cycle of full_frame, when the register holds the frame.
    srs_sel_if sel ();
    srs_decode u_dec (
        .frame      (shift_q),
        .frame_done (full_frame),
        .sel        (sel)
    );

    // ==========================================
    // Per-channel views of the flat register buses
    // One word per channel and per register kind; the read mux below then
    // indexes by the decoded channel number instead of slicing by hand.
    logic [DATA_BITS-1:0] pri_w  [CHANNELS];
    logic [DATA_BITS-1:0] alt_w  [CHANNELS];
    logic [DATA_BITS-1:0] ofs_w  [CHANNELS];
    logic [DATA_BITS-1:0] gain_w [CHANNELS];
    for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
        assign pri_w[c]  = primary_input_reg[c*DATA_BITS +: DATA_BITS];
        assign alt_w[c]  = alternate_input_reg[c*DATA_BITS +: DATA_BITS];
        assign ofs_w[c]  = offset_trim_reg[c*DATA_BITS +: DATA_BITS];
        assign gain_w[c] = gain_trim_reg[c*DATA_BITS +: DATA_BITS];
    end

    // Selected register contents
    // The pin level comes from its synchroniser; an output pin reads as zero
    logic [15:0] pick;
    always_comb begin
        pick = RESET_WORD;
        case (sel.src)
            SRS_SRC_PRI:  pick = pri_w[sel.chan];                         // [RL2]
            SRS_SRC_ALT:  pick = alt_w[sel.chan];
            SRS_SRC_OFS:  pick = ofs_w[sel.chan];
            SRS_SRC_GAIN: pick = gain_w[sel.chan];
            SRS_SRC_CTRL: pick = control_reg;                             // [RL3]
            SRS_SRC_DAC0: pick = offset_dac_zero;
            SRS_SRC_DAC1: pick = offset_dac_one;
            SRS_SRC_AB0:  pick = ab_select_zero;
            SRS_SRC_AB1:  pick = ab_select_one;
            SRS_SRC_GPIO: pick = {15'h0000, gpio_s_q[1] & !gpio_is_output}; // [RL5] [RL7]
            default:      pick = RESET_WORD;
        endcase
    end

    // ==========================================
    // Response latched at end of request, shifted next frame
    // The registers are sampled once, at the end of the request frame, so a
    // value that changes before the response frame is reported as it stood
    // at the request: a deliberate snapshot.
    // The word shifts on synced sclk rises, so each bit has the rest of the high
    // phase of sclk to settle before the host samples it on the fall.
    // At the end of every good frame armed_q is reloaded from that frame's
    // own decode, so a readback request sent in place of the no-op is
    // honoured in turn, while any other frame cancels the response.
    localparam int PAD_BITS = FRAME_BITS - DATA_BITS;
    logic [FRAME_BITS-1:0] resp_word;
    assign resp_word = {{PAD_BITS{1'b0}}, pick};
    logic [FRAME_BITS-1:0] resp_q;
    logic                  armed_q;
    always_ff @(posedge clk) begin
        if (rst) begin
            resp_q  <= '0;
            armed_q <= 1'b0;
        end else if (full_frame) begin
            armed_q <= sel.valid;                                   // [RL8]
            resp_q  <= sel.valid ? resp_word : '0;                  // [RL9]
        end else if (armed_q && in_frame && sclk_rise) begin
            resp_q <= {resp_q[FRAME_BITS-2:0], 1'b0};               // [RL9]
        end else if (frame_end) begin
            armed_q <= 1'b0;
        end
    end
    // Serial data out, registered
    // Held low outside response frames so a shared line sees no stale bits
    always_ff @(posedge clk) begin
        if (rst)
            sdo <= 1'b0;
        else
            sdo <= armed_q && in_frame ? resp_q[FRAME_BITS-1] : 1'b0;
    end
endmodule // srs_readback

// file: testbench/srs_monitor.sv
// Port checker for srs_readback
// Assumes one clock domain; bound to every srs_readback instance
`timescale 1ns/1ps
module srs_monitor (
    // Clock and reset
    input wire logic                         clk,
    input wire logic                         rst,
    // Watched pins
    input wire logic                         sclk,
    input wire logic                         sync_n,
    input wire logic                         sdo,
    input wire logic                         frame_valid,
    input wire logic [srs_pkg::FRAME_BITS-1:0] frame_word
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================
    // Frame and response timing
    property p_fv_once; frame_valid |=> (!frame_valid) [*8]; endproperty
    a_fv_once: assert property (p_fv_once) else $error("frame_valid too long");
    property p_fv_end; frame_valid |-> $past(sync_n, 1) && $past(sync_n, 3); endproperty
    a_fv_end: assert property (p_fv_end) else $error("frame_valid mid frame");
    property p_fv_mid; (!sync_n) [*5] |-> !frame_valid; endproperty
    a_fv_mid: assert property (p_fv_mid) else $error("frame_valid in frame");
    property p_sdo_idle; sync_n [*6] |-> !sdo; endproperty
    a_sdo_idle: assert property (p_sdo_idle) else $error("sdo busy when idle");
    property p_sdo_hold; (!sclk) [*5] |-> $stable(sdo); endproperty
    a_sdo_hold: assert property (p_sdo_hold) else $error("sdo moved, sclk low");
    property p_word; !frame_valid |-> $stable(frame_word); endproperty
    a_word: assert property (p_word) else $error("frame_word moved alone");
    property p_rst;
        disable iff (1'b0) rst |=> !frame_valid && !sdo && frame_word == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
endmodule // srs_monitor
bind srs_readback srs_monitor u_srs_monitor (.clk, .rst, .sclk, .sync_n, .sdo,
    .frame_valid, .frame_word);

// file: testbench/srs_host_model.sv
// Host model: drives one serial frame, captures sdo
// Assumes clk at 200 MHz; sclk idles high
`timescale 1ns/1ps
module srs_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic     sclk,
    output logic     sync_n,
    output logic     sdi,
    input wire logic sdo
);
    initial begin
        sclk <= 1'b1;
        sync_n <= 1'b1;
        sdi <= 1'b0;
    end
    // One 24-bit frame, MSB first, sdi taken on sclk fall
    task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
        @(posedge clk) sync_n <= 1'b0;
        repeat (6) @(posedge clk);
        for (int i = 23; i >= 0; i--) begin
            sdi <= tx[i];
            repeat (2) @(posedge clk);
            @(negedge clk) rx[i] = sdo;
            @(posedge clk) sclk <= 1'b0;
            repeat (6) @(posedge clk);
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
        end
        sync_n <= 1'b1;
        sdi <= ~sdi; // Released line shows no stale value
    endtask
endmodule // srs_host_model

// file: testbench/tb.sv
// Testbench for srs_readback
// Assumes srs_host_model and srs_monitor compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
    $display("wrong value %s exp %h got %h", nm, e, g); miscompares++; end end
module tb;
    import srs_pkg::*;
    logic            clk, rst, sclk, sync_n, sdi, sdo, g_out, g_pin, frame_valid;
    logic [127:0]    regs [4];
    logic [15:0]     sys [5];
    logic [23:0]     frame_word, rx;
    int              miscompares = 0, n_tests = 0, cyc = 0;
    logic [8:0]      codes [5] = '{SEL_CONTROL, SEL_OFFSET_DAC_ZERO, SEL_OFFSET_DAC_ONE, SEL_AB0, SEL_AB1};
    int              cs [3] = '{0, 5, 7};
    srs_readback #(.CHANNELS(8)) u_srs_readback (.clk, .rst, .sclk, .sync_n, .sdi, .sdo,
        .primary_input_reg(regs[0]), .alternate_input_reg(regs[1]),
        .offset_trim_reg(regs[2]), .gain_trim_reg(regs[3]), .control_reg(sys[0]),
        .offset_dac_zero(sys[1]), .offset_dac_one(sys[2]), .ab_select_zero(sys[3]),
        .ab_select_one(sys[4]), .gpio_is_output(g_out), .gpio_pin(g_pin),
        .frame_valid, .frame_word);
    srs_host_model u_srs_host_model (.clk, .sclk, .sync_n, .sdi, .sdo);
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (miscompares == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // One frame: check frame_valid, captured sdo and captured frame word
    task automatic frame(input logic [23:0] tx, input logic [23:0] ex);
        logic seen;
        seen = 1'b0;
        u_srs_host_model.xfer(tx, rx);
        for (int i = 0; i < 10; i++) begin
            @(negedge clk) if (frame_valid === 1'b1) seen = 1'b1;
        end
        `CHK("frame_valid", 1'b1, seen)
        `CHK("frame_word", tx, frame_word)
        `CHK("sdo", ex, rx)
    endtask
    task automatic readback(input logic [8:0] sel, input logic [6:0] lo, input logic [15:0] v);
        frame({MODE_SPECIAL, FUNC_READBACK, sel, lo}, 24'h0);
        frame(24'h0, {8'h00, v});
    endtask
    task automatic t_channels();
        for (int g = 0; g < 4; g++) begin
            for (int k = 0; k < 3; k++) begin
                readback({3'(g), 3'(cs[k]), 3'(cs[k])}, 7'h7F, {4'(g + 1), 4'(cs[k]), 8'hA5});
            end
        end
    endtask
    task automatic t_system();
        for (int i = 0; i < 5; i++) begin
            readback(codes[i], 7'h2A, {8'hC3, 8'(i + 1)});
        end
    endtask
    task automatic t_gpio();
        @(posedge clk) g_pin <= 1'b1;
        readback(SEL_GPIO, 7'h00, 16'h0001);
        @(posedge clk) g_pin <= 1'b0;
        readback(SEL_GPIO, 7'h00, 16'h0000);
        @(posedge clk) {g_out, g_pin} <= 2'b11;
        readback(SEL_GPIO, 7'h00, 16'h0000);
    endtask
    task automatic t_refuse();
        frame({MODE_SPECIAL, 6'h01, 16'h0000}, 24'h0);
        frame(24'h0, 24'h0);
        frame({2'h3, FUNC_READBACK, SEL_CONTROL, 7'h00}, 24'h0);
        frame(24'h0, 24'h0);
        readback(9'h104, 7'h00, 16'h0000);
    endtask
    // Main sequence
    initial begin
        rst <= 1'b1;
        g_out <= 1'b0;
        g_pin <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            for (int c = 0; c < 8; c++) regs[k][c*16+:16] <= {4'(k + 1), 4'(c), 8'hA5};
        end
        for (int i = 0; i < 5; i++) sys[i] <= {8'hC3, 8'(i + 1)};
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_channels();
        t_system();
        t_gpio();
        t_refuse();
        report_and_stop();
    end
endmodule // tb
